// *** verilog/srp_pkg.sv ***
// Shared constants and types for the serial radio packet buffer ends.
// Assumes a single 200 MHz reference clock shared by both ends.
`default_nettype none
package srp_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  // Host character: start, 8 data, stop
  localparam logic [3:0] CHAR_BITS = 4'hA;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  // End-of-data gap in bit times: two characters
  localparam logic [4:0] GAP_BITS = 5'h14;
  localparam logic [7:0] BUF_BYTES = 8'hB4;
  localparam logic [7:0] NOT_READY_MARGIN = 8'h02;
  // Baud selection codes
  localparam logic [2:0] BAUD_2400 = 3'h0;
  localparam logic [2:0] BAUD_4800 = 3'h1;
  localparam logic [2:0] BAUD_9600 = 3'h2;
  localparam logic [2:0] BAUD_19200 = 3'h3;
  localparam logic [2:0] BAUD_38400 = 3'h4;
  localparam logic [2:0] BAUD_DEFAULT = BAUD_19200;
  localparam int unsigned RATE_2400 = 2400;
  localparam int unsigned RATE_4800 = 4800;
  localparam int unsigned RATE_9600 = 9600;
  localparam int unsigned RATE_19200 = 19200;
  localparam int unsigned RATE_38400 = 38400;
  // Configuration command opcodes (upper nibble of a command byte)
  localparam logic [3:0] CMD_BAUD = 4'h1;
  localparam logic [3:0] CMD_CHAN = 4'h2;
  localparam logic [3:0] CMD_POWER = 4'h3;
  localparam logic [3:0] RESET_CHAN = 4'h0;
  localparam logic [3:0] RESET_POWER = 4'hF;
  // Over-air Manchester bit time and packet air time budget
  localparam int unsigned AIR_BIT_US = 100;
  localparam int unsigned AIR_HALF_CYCLES = CLK_HZ / US_PER_S * AIR_BIT_US / 2;
  localparam int unsigned RF_OVERHEAD_US = 13200;
  localparam int unsigned RF_BYTE_US = 800;
  localparam int unsigned RF_OVERHEAD_CYCLES = CLK_HZ / US_PER_S * RF_OVERHEAD_US;
  localparam int unsigned RF_BYTE_CYCLES = CLK_HZ / US_PER_S * RF_BYTE_US;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SYNC = 3'h1,
    ST_SEND = 3'h2,
    ST_RECV = 3'h3,
    ST_DELIVER = 3'h4
  } srp_dev_state_type;

  function automatic logic [16:0] srp_baud_div(input logic [2:0] code,
                                               input int unsigned clk_hz);
    case (code)
      BAUD_2400: srp_baud_div = 17'(clk_hz / RATE_2400);
      BAUD_4800: srp_baud_div = 17'(clk_hz / RATE_4800);
      BAUD_9600: srp_baud_div = 17'(clk_hz / RATE_9600);
      BAUD_38400: srp_baud_div = 17'(clk_hz / RATE_38400);
      default: srp_baud_div = 17'(clk_hz / RATE_19200);
    endcase
  endfunction
endpackage
`default_nettype wire

// *** verilog/srp_link_if.sv ***
// Host-side pins between the radio packet device and its host.
// Both ends run on the same reference clock; receivers still synchronise.
`timescale 1ns/100ps
`default_nettype none
interface srp_link_if;
  logic serial_cmd_in;
  logic serial_rx_out;
  logic not_ready_flag;
  logic host_ready_n;
  modport device (
    input serial_cmd_in,
    input host_ready_n,
    output serial_rx_out,
    output not_ready_flag
  );
  modport host (
    output serial_cmd_in,
    output host_ready_n,
    input serial_rx_out,
    input not_ready_flag
  );
endinterface
`default_nettype wire

// *** verilog/srp_uart.sv ***
// Asynchronous serial character transmitter and receiver, 8N1.
// Assumes div_in is the clock count of one bit and stays stable while busy.
`timescale 1ns/100ps
`default_nettype none
module srp_uart (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [16:0] div_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic tx_line_out,
  input wire logic rx_line_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_busy_out,
  output logic bit_tick_out
);
  logic [16:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_bits, next_tx_bits;
  logic [9:0] tx_shift, next_tx_shift;
  logic rx_s1, rx_s2, rx_s3;
  logic [16:0] rx_cnt, next_rx_cnt;
  logic [3:0] rx_bits, next_rx_bits;
  logic [8:0] rx_sh, next_rx_sh;
  logic [7:0] rx_data, next_rx_data;
  logic rx_valid, next_rx_valid;
  logic [16:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  logic [16:0] div_last;

  assign div_last = div_in - 17'h00001;
  assign tx_ready_out = (tx_bits == 4'h0);
  assign tx_line_out = tx_shift[0];
  assign rx_data_out = rx_data;
  assign rx_valid_out = rx_valid;
  assign rx_busy_out = (rx_bits != 4'h0);
  assign bit_tick_out = tick;

  always_comb begin
    next_tx_cnt = tx_cnt;
    next_tx_bits = tx_bits;
    next_tx_shift = tx_shift;
    if (tx_bits == 4'h0) begin
      if (tx_valid_in) begin
        // Start bit low, stop bit high, every byte value passes as is
        next_tx_shift = {1'b1, tx_data_in, 1'b0};
        next_tx_bits = srp_pkg::CHAR_BITS;
        next_tx_cnt = '0;
      end
    end else if (tx_cnt == div_last) begin
      next_tx_cnt = '0;
      next_tx_shift = {1'b1, tx_shift[9:1]};
      next_tx_bits = tx_bits - 4'h1;
    end else begin
      next_tx_cnt = tx_cnt + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_cnt <= '0;
      tx_bits <= '0;
      tx_shift <= '1;
    end else begin
      tx_cnt <= next_tx_cnt;
      tx_bits <= next_tx_bits;
      tx_shift <= next_tx_shift;
    end
  end

  always_comb begin
    next_rx_cnt = rx_cnt;
    next_rx_bits = rx_bits;
    next_rx_sh = rx_sh;
    next_rx_data = rx_data;
    next_rx_valid = 1'b0;
    if (rx_bits == 4'h0) begin
      if (rx_s3 && !rx_s2) begin
        // Falling edge: first sample lands mid start bit
        next_rx_bits = srp_pkg::CHAR_BITS;
        next_rx_cnt = {1'b0, div_in[16:1]};
      end
    end else if (rx_cnt == div_last) begin
      next_rx_cnt = '0;
      next_rx_bits = rx_bits - 4'h1;
      if (rx_bits == srp_pkg::CHAR_BITS && rx_s2) begin
        next_rx_bits = 4'h0;
      end else if (rx_bits == 4'h1) begin
        if (!rx_sh[0] && rx_s2) begin
          next_rx_data = rx_sh[8:1];
          next_rx_valid = 1'b1;
        end
      end else begin
        next_rx_sh = {rx_s2, rx_sh[8:1]};
      end
    end else begin
      next_rx_cnt = rx_cnt + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_cnt <= '0;
      rx_bits <= '0;
      rx_sh <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_s1 <= rx_line_in;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      rx_cnt <= next_rx_cnt;
      rx_bits <= next_rx_bits;
      rx_sh <= next_rx_sh;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
    end
  end

  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 17'h00001;
    if (tick_cnt >= div_last) begin
      next_tick_cnt = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// *** verilog/srp_device.sv ***
// Radio packet device end: host serial in, packet buffer, Manchester radio,
// checked delivery back to the host.
// Assumes the radio front end gives a clean logic level on radio_rx_in.
// Functional notes
// - Not-ready low when accepting, high otherwise
// - Host drives host-ready low when able
// - Handshake mode: deliver only while host-ready low
// - Host sends at most 180 bytes per packet
// - Load buffer until full or two-byte gap
// - Then transmit buffer Manchester coded over air
// - Decode heard packets into own receive buffer
// - After good check stream buffer to host
// - All byte values 00 to FF pass transparently
// - Programmable baud, default 19,200
// - Serial input accepts configuration commands
// - No acknowledgement or retry; send once
// - Host waits for air time before next packet
// - Receiving host always ready for data
// - Host should repeat packets for reliability
// - Characters are 1 start, 8 data, 1 stop
// - Idle gap fixed at two character times
// - Not-ready rises with two slots free
`timescale 1ns/100ps
`default_nettype none
module srp_device #(
  parameter int unsigned CLK_HZ_P = srp_pkg::CLK_HZ,
  parameter int unsigned AIR_HALF_P = srp_pkg::AIR_HALF_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  srp_link_if.device link,
  input wire logic handshake_en_in,
  input wire logic cfg_mode_in,
  input wire logic radio_rx_in,
  output logic radio_tx_out,
  output logic radio_tx_en_out,
  output logic [3:0] channel_out,
  output logic [3:0] power_out,
  output logic [2:0] baud_code_out,
  output logic rx_good_out,
  output logic rx_drop_out
);
  localparam logic [15:0] HALF = 16'(AIR_HALF_P);
  localparam logic [15:0] QUART = 16'(AIR_HALF_P / 2);
  localparam logic [15:0] SECOND = 16'(AIR_HALF_P + AIR_HALF_P / 2);
  localparam logic [15:0] BIT_END = 16'(2 * AIR_HALF_P - 1);

  srp_pkg::srp_dev_state_type state, next_state;
  logic [7:0] mem [0:179];
  logic [7:0] next_mem [0:179];
  logic [7:0] count, next_count;
  logic [7:0] idx, next_idx;
  logic [7:0] sum, next_sum;
  logic [7:0] cur, next_cur;
  logic [2:0] bitn, next_bitn;
  logic [15:0] ctr, next_ctr;
  logic [4:0] idle, next_idle;
  logic s1, next_s1;
  logic started, next_started;
  logic radio, next_radio;
  logic tx_en, next_tx_en;
  logic [2:0] baud, next_baud;
  logic [3:0] chan, next_chan;
  logic [3:0] pwr, next_pwr;
  logic good, next_good;
  logic drop, next_drop;
  logic rr1, rr2, rr3, hr1, hr2;
  logic [7:0] send_byte, rx_byte;
  logic send_bit, dlv_valid;
  logic [7:0] urx_data;
  logic urx_valid, urx_busy, utx_ready, tick;

  srp_uart u_uart (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .div_in(srp_pkg::srp_baud_div(baud, CLK_HZ_P)),
    .tx_data_in(mem[idx]),
    .tx_valid_in(dlv_valid),
    .tx_ready_out(utx_ready),
    .tx_line_out(link.serial_rx_out),
    .rx_line_in(link.serial_cmd_in),
    .rx_data_out(urx_data),
    .rx_valid_out(urx_valid),
    .rx_busy_out(urx_busy),
    .bit_tick_out(tick)
  );

  assign radio_tx_out = radio;
  assign radio_tx_en_out = tx_en;
  assign channel_out = chan;
  assign power_out = pwr;
  assign baud_code_out = baud;
  assign rx_good_out = good;
  assign rx_drop_out = drop;
  // Busy outside collection, or when only the in-flight margin is left
  assign link.not_ready_flag = (state != srp_pkg::ST_IDLE) || tx_en ||
    (count >= srp_pkg::BUF_BYTES - srp_pkg::NOT_READY_MARGIN);

  always_comb begin
    send_byte = sum;
    if (idx == 8'h00) begin
      send_byte = count;
    end else if (idx <= count) begin
      send_byte = mem[idx - 8'h01];
    end
  end
  assign send_bit = send_byte[bitn];
  assign rx_byte = {s1, cur[7:1]};

  always_comb begin
    next_state = state;
    next_mem = mem;
    next_count = count;
    next_idx = idx;
    next_sum = sum;
    next_cur = cur;
    next_bitn = bitn;
    next_ctr = ctr;
    next_idle = idle;
    next_s1 = s1;
    next_started = started;
    next_radio = 1'b0;
    next_tx_en = 1'b0;
    next_baud = baud;
    next_chan = chan;
    next_pwr = pwr;
    next_good = 1'b0;
    next_drop = 1'b0;
    dlv_valid = 1'b0;
    case (state)
      srp_pkg::ST_IDLE: begin
        if (urx_valid && cfg_mode_in) begin
          case (urx_data[7:4])
            srp_pkg::CMD_BAUD: begin
              if (urx_data[2:0] <= srp_pkg::BAUD_38400) begin
                next_baud = urx_data[2:0];
              end
            end
            srp_pkg::CMD_CHAN: next_chan = urx_data[3:0];
            srp_pkg::CMD_POWER: next_pwr = urx_data[3:0];
            default: next_baud = baud;
          endcase
        end else if (urx_valid && count < srp_pkg::BUF_BYTES) begin
          next_mem[count] = urx_data;
          next_count = count + 8'h01;
          next_sum = ((count == 8'h00) ? 8'h00 : sum) + urx_data;
          next_idle = '0;
        end else if (tick && !urx_busy && idle != srp_pkg::GAP_BITS) begin
          next_idle = idle + 5'h01;
        end
        if (count == srp_pkg::BUF_BYTES || (count != 8'h00 &&
            idle == srp_pkg::GAP_BITS && !urx_busy)) begin
          next_state = srp_pkg::ST_SYNC;
          next_ctr = '0;
          next_idx = '0;
          next_bitn = '0;
        end else if (count == 8'h00 && rr2 && !rr3) begin
          next_state = srp_pkg::ST_RECV;
          next_ctr = '0;
          next_idx = '0;
          next_bitn = '0;
          next_sum = '0;
          next_started = 1'b0;
        end
      end
      srp_pkg::ST_SYNC: begin
        // One Manchester one as the receiver's alignment edge
        next_tx_en = 1'b1;
        next_radio = (ctr < HALF);
        next_ctr = ctr + 16'h0001;
        if (ctr == BIT_END) begin
          next_state = srp_pkg::ST_SEND;
          next_ctr = '0;
        end
      end
      srp_pkg::ST_SEND: begin
        // Length, data, checksum; LSB first, a one is high then low
        next_tx_en = 1'b1;
        next_radio = (ctr < HALF) ? send_bit : !send_bit;
        next_ctr = ctr + 16'h0001;
        if (ctr == BIT_END) begin
          next_ctr = '0;
          next_bitn = bitn + 3'h1;
          if (bitn == srp_pkg::LAST_DATA_BIT) begin
            next_idx = idx + 8'h01;
            if (idx == count + 8'h01) begin
              next_state = srp_pkg::ST_IDLE;
              next_count = '0;
              next_idle = '0;
            end
          end
        end
      end
      srp_pkg::ST_RECV: begin
        next_ctr = ctr + 16'h0001;
        if (ctr == BIT_END) begin
          next_ctr = '0;
        end
        if (ctr == QUART) begin
          next_s1 = rr2;
        end
        if (ctr == SECOND) begin
          if (s1 == rr2 || (!started && !s1)) begin
            next_state = srp_pkg::ST_IDLE;
            next_count = '0;
            next_drop = 1'b1;
          end else if (!started) begin
            next_started = 1'b1;
          end else begin
            next_cur = rx_byte;
            next_bitn = bitn + 3'h1;
            if (bitn == srp_pkg::LAST_DATA_BIT) begin
              next_idx = idx + 8'h01;
              if (idx == 8'h00) begin
                next_count = rx_byte;
                if (rx_byte == 8'h00 || rx_byte > srp_pkg::BUF_BYTES) begin
                  next_state = srp_pkg::ST_IDLE;
                  next_count = '0;
                  next_drop = 1'b1;
                end
              end else if (idx <= count) begin
                next_mem[idx - 8'h01] = rx_byte;
                next_sum = sum + rx_byte;
              end else if (rx_byte == sum) begin
                next_state = srp_pkg::ST_DELIVER;
                next_idx = '0;
                next_good = 1'b1;
              end else begin
                next_state = srp_pkg::ST_IDLE;
                next_count = '0;
                next_drop = 1'b1;
              end
            end
          end
        end
      end
      srp_pkg::ST_DELIVER: begin
        if (idx == count) begin
          if (utx_ready) begin
            next_state = srp_pkg::ST_IDLE;
            next_count = '0;
            next_idle = '0;
          end
        end else if (utx_ready && (!handshake_en_in || !hr2)) begin
          dlv_valid = 1'b1;
          next_idx = idx + 8'h01;
        end
      end
      default: next_state = srp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    mem <= next_mem;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= srp_pkg::ST_IDLE;
      count <= '0;
      idx <= '0;
      sum <= '0;
      cur <= '0;
      bitn <= '0;
      ctr <= '0;
      idle <= '0;
      s1 <= 1'b0;
      started <= 1'b0;
      radio <= 1'b0;
      tx_en <= 1'b0;
      baud <= srp_pkg::BAUD_DEFAULT;
      chan <= srp_pkg::RESET_CHAN;
      pwr <= srp_pkg::RESET_POWER;
      good <= 1'b0;
      drop <= 1'b0;
      rr1 <= 1'b0;
      rr2 <= 1'b0;
      rr3 <= 1'b0;
      hr1 <= 1'b1;
      hr2 <= 1'b1;
    end else begin
      state <= next_state;
      count <= next_count;
      idx <= next_idx;
      sum <= next_sum;
      cur <= next_cur;
      bitn <= next_bitn;
      ctr <= next_ctr;
      idle <= next_idle;
      s1 <= next_s1;
      started <= next_started;
      radio <= next_radio;
      tx_en <= next_tx_en;
      baud <= next_baud;
      chan <= next_chan;
      pwr <= next_pwr;
      good <= next_good;
      drop <= next_drop;
      rr1 <= radio_rx_in;
      rr2 <= rr1;
      rr3 <= rr2;
      hr1 <= link.host_ready_n;
      hr2 <= hr1;
    end
  end
endmodule
`default_nettype wire

// *** verilog/srp_host.sv ***
// Host end: streams packets to the device and takes its delivered bytes.
// Assumes the device runs at the same baud code as baud_code_in.
`timescale 1ns/100ps
`default_nettype none
module srp_host #(
  parameter int unsigned CLK_HZ_P = srp_pkg::CLK_HZ,
  parameter int unsigned OVERHEAD_P = srp_pkg::RF_OVERHEAD_CYCLES,
  parameter int unsigned BYTE_P = srp_pkg::RF_BYTE_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  srp_link_if.host link,
  input wire logic [2:0] baud_code_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic rx_enable_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out
);
  logic nr1, nr2;
  logic [7:0] pkt, next_pkt;
  logic [4:0] idle, next_idle;
  logic [25:0] hold, next_hold;
  logic rdy_n, next_rdy_n;
  logic utx_ready, tick, tx_fire;

  srp_uart u_uart (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .div_in(srp_pkg::srp_baud_div(baud_code_in, CLK_HZ_P)),
    .tx_data_in(tx_data_in),
    .tx_valid_in(tx_fire),
    .tx_ready_out(utx_ready),
    .tx_line_out(link.serial_cmd_in),
    .rx_line_in(link.serial_rx_out),
    .rx_data_out(rx_data_out),
    .rx_valid_out(rx_valid_out),
    .rx_busy_out(),
    .bit_tick_out(tick)
  );

  assign link.host_ready_n = rdy_n;
  // Stall while the device is busy, the packet is full or air time runs
  assign tx_ready_out = utx_ready && !nr2 && hold == '0 &&
    pkt < srp_pkg::BUF_BYTES &&
    (pkt == 8'h00 || idle != srp_pkg::GAP_BITS);
  assign tx_fire = tx_valid_in && tx_ready_out;

  always_comb begin
    next_pkt = pkt;
    next_idle = idle;
    next_hold = hold;
    next_rdy_n = !rx_enable_in;
    if (hold != '0) begin
      next_hold = hold - 26'h0000001;
    end
    if (tx_fire) begin
      next_pkt = pkt + 8'h01;
      next_idle = '0;
    end else if (tick && utx_ready && idle != srp_pkg::GAP_BITS) begin
      next_idle = idle + 5'h01;
    end
    if (pkt != 8'h00 && idle == srp_pkg::GAP_BITS) begin
      // Packet closed: wait out its air time before the next one
      next_hold = 26'(OVERHEAD_P + pkt * BYTE_P);
      next_pkt = '0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      nr1 <= 1'b1;
      nr2 <= 1'b1;
      pkt <= '0;
      idle <= '0;
      hold <= '0;
      rdy_n <= 1'b1;
    end else begin
      nr1 <= link.not_ready_flag;
      nr2 <= nr1;
      pkt <= next_pkt;
      idle <= next_idle;
      hold <= next_hold;
      rdy_n <= next_rdy_n;
    end
  end
endmodule
`default_nettype wire

// *** test/srp_link_chk_sva.sv ***
// Checker for the first host link and the radio status of its device.
// Assumes one clock; DIV is clocks per serial bit, AIR per air half-bit.
`timescale 1ns/100ps
`default_nettype none
module srp_link_chk #(
  parameter int unsigned DIV = 104,
  parameter int unsigned AIR = 200
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic serial_cmd_in,
  input wire logic serial_rx_out,
  input wire logic not_ready_flag,
  input wire logic host_ready_n,
  input wire logic handshake_en_in,
  input wire logic cfg_mode_in,
  input wire logic radio_tx_en_out,
  input wire logic rx_good_out,
  input wire logic rx_drop_out
);
  logic [31:0] hi_cnt, rx_hi, en_cnt;
  logic [31:0] next_hi_cnt, next_rx_hi, next_en_cnt;
  logic pend, pend_rx, next_pend, next_pend_rx;
  // Idle spans of both lines, air length, data and delivery pending
  always_comb begin
    next_hi_cnt = serial_cmd_in ? hi_cnt + 32'h1 : 32'h0;
    next_rx_hi = serial_rx_out ? rx_hi + 32'h1 : 32'h0;
    next_en_cnt = radio_tx_en_out ? en_cnt + 32'h1 : 32'h0;
    next_pend = pend;
    if (!serial_cmd_in && !cfg_mode_in && !not_ready_flag) begin
      next_pend = 1'b1;
    end else if (!radio_tx_en_out && en_cnt != 32'h0) begin
      next_pend = 1'b0;
    end
    next_pend_rx = pend_rx;
    if (rx_good_out) begin
      next_pend_rx = 1'b1;
    end else if (!serial_rx_out) begin
      next_pend_rx = 1'b0;
    end
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hi_cnt <= 32'h0;
      rx_hi <= 32'h0;
      en_cnt <= 32'h0;
      pend <= 1'b0;
      pend_rx <= 1'b0;
    end else begin
      hi_cnt <= next_hi_cnt;
      rx_hi <= next_rx_hi;
      en_cnt <= next_en_cnt;
      pend <= next_pend;
      pend_rx <= next_pend_rx;
    end
  end
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  a_idle_ready: assert property ($fell(rst_in) |-> !not_ready_flag)
    else $error("not ready set after reset");
  a_air_busy: assert property (radio_tx_en_out |-> not_ready_flag)
    else $error("ready while sending");
  a_gap_close: assert property (
    pend && hi_cnt == 29 * DIV |-> radio_tx_en_out)
    else $error("packet not closed after gap");
  a_frame_len: assert property (
    $fell(radio_tx_en_out) |->
    en_cnt % (16 * AIR) == 2 * AIR && en_cnt > 48 * AIR)
    else $error("air frame length wrong");
  a_hs_hold: assert property (
    (handshake_en_in && host_ready_n && rx_hi > 10 * DIV)[*6]
    |=> serial_rx_out)
    else $error("delivery while host not ready");
  a_deliver_soon: assert property (
    pend_rx && (!handshake_en_in || !host_ready_n) |->
    ##[0:40] !serial_rx_out)
    else $error("delivery did not start");
  a_good_drop: assert property (rx_good_out |-> !rx_drop_out)
    else $error("good and drop together");
  a_drop_quiet: assert property (
    rx_drop_out && serial_rx_out |=> serial_rx_out[*8])
    else $error("output after drop");
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Bench: two host and device pairs, the devices joined by a radio path.
// Assumes the package, interface and design modules are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned HZ = 2000000;
  localparam int unsigned AIR = 200;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic flip = 1'b0;
  logic [7:0] td[2] = '{8'h00, 8'h00};
  logic tv[2] = '{1'b0, 1'b0};
  logic en[2] = '{1'b1, 1'b1};
  logic hs[2] = '{1'b0, 1'b0};
  logic cfg[2] = '{1'b0, 1'b0};
  logic rdy[2], rv[2], rin[2], rtx[2], ten[2], good[2], drop[2];
  logic [7:0] rq[2];
  logic [3:0] chan[2], pwr[2];
  logic [2:0] baud[2];
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 1;
  int n_a = 0;
  int goods = 0;
  int drops = 0;
  int n;
  logic [7:0] exp_a[$];
  logic [7:0] exp_b[$];
  logic [7:0] pk[2];
  srp_link_if lk[2]();
  for (genvar i = 0; i < 2; i++) begin : g_end
    srp_host #(.CLK_HZ_P(HZ), .OVERHEAD_P(1000), .BYTE_P(100)) i_srp_host (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(lk[i].host),
      .baud_code_in(3'h3), .tx_data_in(td[i]), .tx_valid_in(tv[i]),
      .tx_ready_out(rdy[i]), .rx_enable_in(en[i]), .rx_data_out(rq[i]),
      .rx_valid_out(rv[i]));
    srp_device #(.CLK_HZ_P(HZ), .AIR_HALF_P(AIR)) i_srp_device (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(lk[i].device),
      .handshake_en_in(hs[i]), .cfg_mode_in(cfg[i]),
      .radio_rx_in(rin[i]), .radio_tx_out(rtx[i]),
      .radio_tx_en_out(ten[i]), .channel_out(chan[i]), .power_out(pwr[i]),
      .baud_code_out(baud[i]), .rx_good_out(good[i]), .rx_drop_out(drop[i]));
  end
  // Radio path; flip spoils the frame heard by the first device
  assign rin[0] = rtx[1] ^ flip;
  assign rin[1] = rtx[0];
  srp_link_chk #(.DIV(HZ / 19200), .AIR(AIR)) i_srp_link_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .serial_cmd_in(lk[0].serial_cmd_in), .serial_rx_out(lk[0].serial_rx_out),
    .not_ready_flag(lk[0].not_ready_flag), .host_ready_n(lk[0].host_ready_n),
    .handshake_en_in(hs[0]), .cfg_mode_in(cfg[0]),
    .radio_tx_en_out(ten[0]), .rx_good_out(good[0]), .rx_drop_out(drop[0]));
  always #2.5 ref_clk_in = ~ref_clk_in;
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (e !== g) begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic take(ref logic [7:0] q[$], input logic [7:0] g);
    if (q.size() == 0) begin
      chk(8'h00, 8'hFF);
    end else begin
      chk(q.pop_front(), g);
    end
  endtask
  // Offer one byte to host s; keep marks bytes the far host must get
  task automatic put(input int s, input logic [7:0] d, input bit keep);
    int k;
    k = 0;
    @(posedge ref_clk_in);
    td[s] <= d;
    tv[s] <= 1'b1;
    do begin
      @(negedge ref_clk_in);
      k++;
    end while (rdy[s] !== 1'b1 && k < 9000);
    chk(8'h01, {7'h00, rdy[s]});
    @(posedge ref_clk_in);
    tv[s] <= 1'b0;
    if (keep && s == 0) exp_b.push_back(d);
    if (keep && s == 1) exp_a.push_back(d);
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (exp_a.size() + exp_b.size() != 0 && k < 60000) begin
      @(posedge ref_clk_in);
      k++;
    end
    repeat (1000) @(posedge ref_clk_in);
    chk(8'h00, 8'(exp_a.size() + exp_b.size()));
  endtask
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      err_total++;
      conclude();
    end
  end
  always @(negedge ref_clk_in) begin
    goods += int'(good[0] === 1'b1);
    drops += int'(drop[0] === 1'b1);
    if (rv[0] === 1'b1) begin
      n_a++;
      take(exp_a, rq[0]);
    end
    if (rv[1] === 1'b1) take(exp_b, rq[1]);
  end
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    chk(8'h00, {4'h0, chan[0]});
    chk(8'h0F, {4'h0, pwr[0]});
    chk(8'h03, {5'h00, baud[0]});
    cfg[0] <= 1'b1;
    put(0, 8'h25, 0);
    put(0, 8'h37, 0);
    put(0, 8'h17, 0);
    repeat (1200) @(posedge ref_clk_in);
    chk(8'h05, {4'h0, chan[0]});
    chk(8'h07, {4'h0, pwr[0]});
    chk(8'h03, {5'h00, baud[0]});
    cfg[0] <= 1'b0;
    put(0, 8'h00, 1);
    put(0, 8'hFF, 1);
    put(0, 8'($random(seed)), 1);
    drain();
    hs[0] <= 1'b1;
    en[0] <= 1'b0;
    repeat (2) put(1, 8'($random(seed)), 1);
    n = 0;
    while (goods == 0 && n < 40000) begin
      @(posedge ref_clk_in);
      n++;
    end
    repeat (1500) @(posedge ref_clk_in);
    chk(8'h00, 8'(n_a));
    en[0] <= 1'b1;
    drain();
    chk(8'h01, 8'(goods));
    pk[0] = 8'($random(seed));
    pk[1] = 8'($random(seed));
    put(1, pk[0], 0);
    put(1, pk[1], 0);
    n = 0;
    while (ten[1] !== 1'b1 && n < 9000) begin
      @(negedge ref_clk_in);
      n++;
    end
    // Spoil one half-bit inside the checksum byte
    repeat (3 * 16 * AIR + 2 * AIR + 600) @(posedge ref_clk_in);
    flip <= 1'b1;
    repeat (AIR) @(posedge ref_clk_in);
    flip <= 1'b0;
    repeat (2500) @(posedge ref_clk_in);
    chk(8'h01, 8'(drops != 0));
    chk(8'h01, 8'(goods));
    // Send the spoiled packet again; the repeat must get through
    put(1, pk[0], 1);
    put(1, pk[1], 1);
    drain();
    chk(8'h02, 8'(goods));
    conclude();
  end
endmodule
`default_nettype wire
